/* File: rtl/bcs_pkg.sv */
// package: bus cycle status and hold constants and types
package bcs_pkg;

    // ------------------------------------------------------------
    // cycle-status codes, highest bit first
    // ------------------------------------------------------------
    localparam logic [2:0] BCS_CODE_INTERRUPT_ACK_STROBE    = 3'h0;
    localparam logic [2:0] BCS_CODE_IO_RD   = 3'h1;
    localparam logic [2:0] BCS_CODE_IO_WR   = 3'h2;
    localparam logic [2:0] BCS_CODE_HALT    = 3'h3;
    localparam logic [2:0] BCS_CODE_FETCH   = 3'h4;
    localparam logic [2:0] BCS_CODE_MEM_RD  = 3'h5;
    localparam logic [2:0] BCS_CODE_MEM_WR  = 3'h6;
    localparam logic [2:0] BCS_CODE_PASSIVE = 3'h7;

    // ------------------------------------------------------------
    // code field positions
    // ------------------------------------------------------------
    localparam int BCS_BIT_MEM = 2;
    localparam int BCS_BIT_DIR = 1;
    localparam int BCS_BIT_LOW = 0;

    // ------------------------------------------------------------
    // pin synchroniser layout and reset values
    // ------------------------------------------------------------
    localparam int         BCS_SYNC_W   = 3;
    localparam int         BCS_SYNC_HLD = 0;
    localparam int         BCS_SYNC_RDY = 1;
    localparam int         BCS_SYNC_CFG = 2;
    localparam logic       BCS_MODE_MIN = 1'h1;
    localparam logic       BCS_PH_FIRST = 1'h0;
    localparam logic       BCS_PH_MID   = 1'h1;

    typedef enum logic [2:0]
    {
        BCS_TI   = 3'h0,
        BCS_T1   = 3'h1,
        BCS_T2   = 3'h2,
        BCS_T3   = 3'h3,
        BCS_TW   = 3'h4,
        BCS_T4   = 3'h5,
        BCS_HOLD = 3'h6
    } bcs_state_t;

    typedef struct packed
    {
        logic       mem_io;
        logic       dir;
        logic       den_n;
        logic [2:0] status;
    } bcs_pins_t;

    localparam bcs_pins_t BCS_PINS_IDLE = '{mem_io: 1'h1, dir: 1'h1, den_n: 1'h1, status: BCS_CODE_PASSIVE};

endpackage

/* File: rtl/bcs_sync.sv */
// file: two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bcs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    // no reset: pure data pipeline, settles within two edges
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_clock)
    begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* File: rtl/bcs_bus_cycle.sv */
// file: bus cycle sequencer with status, transceiver and hold pins
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bcs_bus_cycle (
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    input  wire logic       i_config_select,
    input  wire logic       i_bus_release_req,
    input  wire logic       i_ready,
    input  wire logic       i_cycle_req,
    input  wire logic [2:0] i_cycle_code,
    output logic            o_cycle_ack,
    output logic            o_bus_release_ack,
    output logic            o_mem_io,
    output logic            o_mem_io_oe,
    output logic            o_transfer_direction,
    output logic            o_transfer_direction_oe,
    output logic            o_transceiver_enable_n,
    output logic            o_transceiver_enable_n_oe,
    output logic [2:0]      o_cycle_status,
    output logic            o_cycle_status_oe
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [bcs_pkg::BCS_SYNC_W-1:0] sync_w;
    logic                           hold_s;
    logic                           rdy_s;

    // request is synchronous already, but a pin is never trusted
    // request synchronised
    bcs_sync #(.WIDTH(bcs_pkg::BCS_SYNC_W)) u_sync (
        .i_clock (i_clock),
        .i_async ({i_config_select, i_ready, i_bus_release_req}),
        .o_sync  (sync_w)
    );
    assign hold_s = sync_w[bcs_pkg::BCS_SYNC_HLD];
    assign rdy_s  = sync_w[bcs_pkg::BCS_SYNC_RDY];

    // ------------------------------------------------------------
    // configuration capture
    // ------------------------------------------------------------
    logic mode_q;
    logic mode_d;

    always_comb
    begin
        mode_d = mode_q;
        if (i_reset)
            mode_d = sync_w[bcs_pkg::BCS_SYNC_CFG];
    end

    always_ff @(posedge i_clock)
        mode_q <= mode_d;

    // ------------------------------------------------------------
    // bus state sequencer
    // ------------------------------------------------------------
    bcs_pkg::bcs_state_t st_q;
    bcs_pkg::bcs_state_t st_d;
    logic                ph_q;
    logic                ph_d;
    logic                pend_q;
    logic                pend_d;
    logic [2:0]          pcode_q;
    logic [2:0]          pcode_d;
    logic [2:0]          run_q;
    logic [2:0]          run_d;
    logic                act_q;
    logic                act_d;
    logic                ack_q;
    logic                ack_d;
    logic                drv_q;
    logic                drv_d;
    logic                take;

    always_comb
    begin
        st_d    = st_q;
        ph_d    = ~ph_q;
        pend_d  = pend_q;
        pcode_d = pcode_q;
        run_d   = run_q;
        act_d   = act_q;
        ack_d   = ack_q;
        drv_d   = drv_q;
        take    = 1'b0;
        case (st_q)
            bcs_pkg::BCS_TI:
            begin
                if (ph_q == bcs_pkg::BCS_PH_FIRST && hold_s)
                begin
                    st_d  = bcs_pkg::BCS_HOLD;
                    ack_d = 1'b1;
                    drv_d = 1'b0;
                end
                else if (ph_q == bcs_pkg::BCS_PH_MID && i_cycle_req && !hold_s)
                begin
                    take    = 1'b1;
                    pend_d  = 1'b1;
                    pcode_d = i_cycle_code;
                    drv_d   = 1'b1;
                    st_d    = bcs_pkg::BCS_T4;
                end
            end
            bcs_pkg::BCS_T1:
                if (ph_q == bcs_pkg::BCS_PH_MID)
                    st_d = bcs_pkg::BCS_T2;
            bcs_pkg::BCS_T2:
                if (ph_q == bcs_pkg::BCS_PH_MID)
                    st_d = bcs_pkg::BCS_T3;
            bcs_pkg::BCS_T3, bcs_pkg::BCS_TW:
                if (ph_q == bcs_pkg::BCS_PH_MID)
                begin
                    if (!rdy_s)
                        st_d = bcs_pkg::BCS_TW;
                    else
                    begin
                        st_d = bcs_pkg::BCS_T4;
                        // pending hold beats a new cycle
                        if (i_cycle_req && !hold_s)
                        begin
                            take    = 1'b1;
                            pend_d  = 1'b1;
                            pcode_d = i_cycle_code;
                        end
                    end
                end
            bcs_pkg::BCS_T4:
            begin
                if (ph_q == bcs_pkg::BCS_PH_FIRST && !pend_q && hold_s)
                begin
                    st_d  = bcs_pkg::BCS_HOLD;
                    ack_d = 1'b1;
                    drv_d = 1'b0;
                    act_d = 1'b0;
                end
                else if (ph_q == bcs_pkg::BCS_PH_MID)
                begin
                    act_d  = pend_q;
                    pend_d = 1'b0;
                    if (pend_q)
                    begin
                        st_d  = bcs_pkg::BCS_T1;
                        run_d = pcode_q;
                    end
                    else
                        st_d = bcs_pkg::BCS_TI;
                end
            end
            bcs_pkg::BCS_HOLD:
                if (ph_q == bcs_pkg::BCS_PH_FIRST && !hold_s)
                begin
                    st_d  = bcs_pkg::BCS_TI;
                    ack_d = 1'b0;
                end
            default:
                st_d = bcs_pkg::BCS_TI;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            st_q    <= bcs_pkg::BCS_TI;
            ph_q    <= bcs_pkg::BCS_PH_FIRST;
            pend_q  <= 1'b0;
            pcode_q <= bcs_pkg::BCS_CODE_PASSIVE;
            run_q   <= bcs_pkg::BCS_CODE_PASSIVE;
            act_q   <= 1'b0;
            ack_q   <= 1'b0;
            drv_q   <= 1'b1;
        end
        else
        begin
            st_q    <= st_d;
            ph_q    <= ph_d;
            pend_q  <= pend_d;
            pcode_q <= pcode_d;
            run_q   <= run_d;
            act_q   <= act_d;
            ack_q   <= ack_d;
            drv_q   <= drv_d;
        end
    end

    // ------------------------------------------------------------
    // pin values, registered from next state
    // ------------------------------------------------------------
    bcs_pkg::bcs_pins_t pins_q;
    bcs_pkg::bcs_pins_t pins_d;
    logic               is_wr;
    logic               xfer;

    always_comb
    begin
        pins_d = bcs_pkg::BCS_PINS_IDLE;
        is_wr  = run_d[bcs_pkg::BCS_BIT_DIR] & ~run_d[bcs_pkg::BCS_BIT_LOW];
        xfer   = act_d && (run_d != bcs_pkg::BCS_CODE_HALT);
        if (drv_d)
        begin
            // direction from code; same bit as status; select
            pins_d.mem_io = pend_d ? pcode_d[bcs_pkg::BCS_BIT_MEM] : run_d[bcs_pkg::BCS_BIT_MEM];
            pins_d.dir    = pend_d ? pcode_d[bcs_pkg::BCS_BIT_DIR] : run_d[bcs_pkg::BCS_BIT_DIR];
            if (xfer)
            begin
                case (st_d)
                    bcs_pkg::BCS_T2: pins_d.den_n = ~(ph_d | is_wr);
                    bcs_pkg::BCS_T3: pins_d.den_n = 1'b0;
                    bcs_pkg::BCS_TW: pins_d.den_n = 1'b0;
                    bcs_pkg::BCS_T4: pins_d.den_n = ph_d;
                    default:         pins_d.den_n = 1'b1;
                endcase
            end
            // status window; change marks start, passive marks end
            case (st_d)
                bcs_pkg::BCS_T1, bcs_pkg::BCS_T2:
                    pins_d.status = run_d;
                bcs_pkg::BCS_T3, bcs_pkg::BCS_TW:
                    pins_d.status = rdy_s ? bcs_pkg::BCS_CODE_PASSIVE : run_d;
                bcs_pkg::BCS_T4, bcs_pkg::BCS_TI:
                    pins_d.status = pend_d ? pcode_d : bcs_pkg::BCS_CODE_PASSIVE;
                default:
                    pins_d.status = bcs_pkg::BCS_CODE_PASSIVE;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            pins_q <= bcs_pkg::BCS_PINS_IDLE;
        else
            pins_q <= pins_d;
    end

    // ------------------------------------------------------------
    // outputs; pins rest at one while released
    // ------------------------------------------------------------
    // float while released
    assign o_mem_io_oe               = drv_q & (mode_q == bcs_pkg::BCS_MODE_MIN);
    assign o_transfer_direction_oe   = o_mem_io_oe;
    assign o_transceiver_enable_n_oe = o_mem_io_oe;
    assign o_cycle_status_oe         = drv_q & (mode_q != bcs_pkg::BCS_MODE_MIN);
    assign o_mem_io                  = pins_q.mem_io;
    assign o_transfer_direction      = pins_q.dir;
    assign o_transceiver_enable_n    = pins_q.den_n;
    assign o_cycle_status            = pins_q.status;
    assign o_bus_release_ack         = ack_q & (mode_q == bcs_pkg::BCS_MODE_MIN);
    assign o_cycle_ack               = take;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic wr_run;
    assign wr_run = (run_q == bcs_pkg::BCS_CODE_IO_WR) || (run_q == bcs_pkg::BCS_CODE_MEM_WR);

    sequence t2_first_s;
        st_q == bcs_pkg::BCS_T2 && ph_q == bcs_pkg::BCS_PH_FIRST && act_q;
    endsequence

    sequence read_enable_s;
        pins_q.den_n ##1 !pins_q.den_n;
    endsequence

    sequence hold_entry_s;
        $rose(ack_q) && drv_q == 1'b0;
    endsequence

    enable_released_a: assert property (@(posedge i_clock) disable iff (i_reset)
        ack_q |-> pins_q.den_n && !o_transceiver_enable_n_oe) else $error("enable driven while released");
    dir_status_eq_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (drv_q && (st_q == bcs_pkg::BCS_T1 || st_q == bcs_pkg::BCS_T2))
        |-> pins_q.dir == pins_q.status[bcs_pkg::BCS_BIT_DIR]) else $error("direction differs from status");
    ack_mid_a: assert property (@(posedge i_clock) disable iff (i_reset)
        hold_entry_s |-> ph_q == bcs_pkg::BCS_PH_MID && $past(hold_s)
        && ($past(st_q) == bcs_pkg::BCS_T4 || $past(st_q) == bcs_pkg::BCS_TI)) else $error("ack not at mid state");
    ack_drop_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (st_q == bcs_pkg::BCS_HOLD && !hold_s && ph_q == bcs_pkg::BCS_PH_FIRST)
        |=> !ack_q && !drv_q) else $error("ack not lowered");
    status_float_a: assert property (@(posedge i_clock) disable iff (i_reset)
        st_q == bcs_pkg::BCS_HOLD |-> !o_cycle_status_oe && pins_q.status == bcs_pkg::BCS_CODE_PASSIVE
        && pins_q.dir && !o_transfer_direction_oe) else $error("status driven during release");
    write_enable_a: assert property (@(posedge i_clock) disable iff (i_reset)
        t2_first_s and wr_run |-> !pins_q.den_n ##1 !pins_q.den_n) else $error("write enable late");
    read_enable_a: assert property (@(posedge i_clock) disable iff (i_reset)
        t2_first_s and !wr_run && run_q != bcs_pkg::BCS_CODE_HALT |-> read_enable_s) else $error("read enable wrong");
    status_run_a: assert property (@(posedge i_clock) disable iff (i_reset)
        (drv_q && st_q == bcs_pkg::BCS_T1) |-> pins_q.status == run_q
        && pins_q.mem_io == run_q[bcs_pkg::BCS_BIT_MEM]) else $error("status or select invalid in T1");
    mode_fixed_a: assert property (@(posedge i_clock) disable iff (i_reset)
        $stable(mode_q)) else $error("configuration changed");
endmodule
`default_nettype wire

/* File: test/bcs_far_side.sv */
// partner model: other bus master and slow memory on the pulled-up pins
`timescale 1ns/1ps
`default_nettype none
module bcs_far_side (
    input  wire logic       i_clock,
    input  wire logic       i_hold_cmd,
    input  wire logic [3:0] i_waits,
    input  wire logic       i_dir,
    input  wire logic       i_den_n,
    input  wire logic [2:0] i_status,
    output logic            o_hold,
    output logic            o_ready
);
    // ------------------------------------------------------------
    // release request
    // ------------------------------------------------------------
    logic [3:0] cnt_q  = 4'h0;
    logic       busy_q = 1'b0;
    logic       busy;

    initial o_hold = 1'b0;
    // held while commanded, changes only on clock
    always @(posedge i_clock) o_hold <= i_hold_cmd;

    // ------------------------------------------------------------
    // ready: reads seen from the address phase so waits can land
    // ------------------------------------------------------------
    assign busy = !i_dir || !i_den_n || (i_status != 3'h7);
    always @(posedge i_clock)
    begin
        busy_q <= busy;
        if (busy && !busy_q)
            cnt_q <= i_waits;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
    assign o_ready = (cnt_q == 4'h0);
endmodule
`default_nettype wire

/* File: test/bcs_bus_cycle_tb.sv */
// testbench: bus cycle pins, release handshake and status codes
`timescale 1ns/1ps
`default_nettype none
module bcs_bus_cycle_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               clock    = 1'b0;
    logic               reset    = 1'b1;
    logic               cfg      = 1'b1;
    logic               req      = 1'b0;
    logic [2:0]         code     = 3'h0;
    logic               hold_cmd = 1'b0;
    logic [3:0]         waits    = 4'h0;
    logic               first_q  = 1'b1;
    logic               hold, ready, ack, rel_ack;
    logic               mem, mem_oe, dir, dir_oe, transceiver_enable_n, den_oe, st_oe;
    logic [2:0]         st;
    bcs_pkg::bcs_pins_t pins;
    int                 mismatches = 0;
    int                 n_checks   = 0;

    always #5 clock = ~clock;
    // released lines rest at one
    assign pins = '{mem_io: mem_oe ? mem : 1'h1, dir: dir_oe ? dir : 1'h1,
                    den_n: den_oe ? transceiver_enable_n : 1'h1, status: st_oe ? st : 3'h7};

    bcs_bus_cycle dut (
        .i_clock(clock), .i_reset(reset), .i_config_select(cfg),
        .i_bus_release_req(hold), .i_ready(ready), .i_cycle_req(req),
        .i_cycle_code(code), .o_cycle_ack(ack), .o_bus_release_ack(rel_ack),
        .o_mem_io(mem), .o_mem_io_oe(mem_oe), .o_transfer_direction(dir),
        .o_transfer_direction_oe(dir_oe), .o_transceiver_enable_n(transceiver_enable_n),
        .o_transceiver_enable_n_oe(den_oe), .o_cycle_status(st), .o_cycle_status_oe(st_oe)
    );
    bcs_far_side far (
        .i_clock(clock), .i_hold_cmd(hold_cmd), .i_waits(waits), .i_dir(pins.dir),
        .i_den_n(pins.den_n), .i_status(pins.status), .o_hold(hold), .o_ready(ready)
    );

    // ------------------------------------------------------------
    // common tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic timeout(input string name);
        mismatches++;
        $display("CHECK FAILED %s expected done seen timeout", name);
        stop_test();
    endtask

    // config needs two sync flops, so reset is longer than two cycles
    task automatic do_reset(input logic c);
        @(negedge clock);
        reset   = 1'b1;
        cfg     = c;
        first_q = c;
        repeat (4) @(negedge clock);
        reset = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check("rel_ack", rel_ack, 1'b0);
        check("oe", {mem_oe, dir_oe, den_oe, st_oe}, first_q ? 4'hE : 4'h1);
        check("idle", {1'b0, pins.mem_io, pins.dir, pins.den_n}, 4'h7);
        check("idle_st", {1'b0, pins.status}, 4'h7);
        $display("reset test done");
    endtask

    task automatic run_cycle(input logic [2:0] c, input logic [3:0] w);
        bcs_pkg::bcs_pins_t cap [24];
        int   i;
        int   n_den;
        int   n_st;
        logic wr;
        wr    = (c == bcs_pkg::BCS_CODE_IO_WR) || (c == bcs_pkg::BCS_CODE_MEM_WR);
        waits = w;
        code  = c;
        req   = 1'b1;
        i     = 0;
        #1;
        while (ack !== 1'b1)
        begin
            @(negedge clock);
            #1;
            i++;
            if (i > 40)
                timeout("cycle_ack");
        end
        @(negedge clock);
        req   = 1'b0;
        n_den = 0;
        n_st  = 0;
        for (int k = 0; k < 24; k++)
        begin
            cap[k] = pins;
            n_den += (pins.den_n === 1'b0);
            n_st  += (pins.status === c);
            @(negedge clock);
        end
        if (first_q && w == 4'h0)
        begin
            // select and direction from lead-in to final T4
            check("dir", cap[0].dir, c[1]);
            check("mem_io", cap[0].mem_io, c[2]);
            check("dir_end", cap[9].dir, c[1]);
            check("mem_io_end", cap[9].mem_io, c[2]);
            check("den_t2", cap[4].den_n, !wr);
            check("den_len", 4'(n_den), (c == bcs_pkg::BCS_CODE_HALT) ? 4'h0 : wr ? 4'h5 : 4'h4);
        end
        else if (first_q)
            check("den_wait", n_den > 4, 1'b1);
        else if (w == 4'h0)
        begin
            check("st_code", cap[0].status, c);
            check("st_len", 4'(n_st), 4'h6);
            check("st_end", cap[6].status, bcs_pkg::BCS_CODE_PASSIVE);
        end
        else
            check("st_wait", n_st > 6, 1'b1);
        $display("cycle %h waits %h done", c, w);
    endtask

    task automatic test_hold();
        int i;
        hold_cmd = 1'b1;
        i        = 0;
        while ((first_q ? rel_ack : !st_oe) !== 1'b1)
        begin
            @(negedge clock);
            i++;
            if (i > 20)
                timeout("release");
        end
        check("rel_oe", {mem_oe, dir_oe, den_oe, st_oe}, 4'h0);
        check("rel_pins", {1'b0, pins.mem_io, pins.dir, pins.den_n}, 4'h7);
        check("rel_st", {1'b0, pins.status}, 4'h7);
        check("rel_ack", rel_ack, first_q);
        req  = 1'b1;
        code = bcs_pkg::BCS_CODE_MEM_RD;
        repeat (8)
        begin
            @(negedge clock);
            #1;
            check("ack_held", ack, 1'b0);
        end
        req      = 1'b0;
        hold_cmd = 1'b0;
        i        = 0;
        while (rel_ack !== 1'b0)
        begin
            @(negedge clock);
            i++;
            if (i > 20)
                timeout("release_end");
        end
        repeat (6) @(negedge clock);
        check("oe_idle", {mem_oe, dir_oe, den_oe, st_oe}, 4'h0);
        run_cycle(bcs_pkg::BCS_CODE_MEM_RD, 4'h0);
        check("oe_back", {mem_oe, dir_oe, den_oe, st_oe}, first_q ? 4'hE : 4'h1);
        $display("hold test done");
    endtask

    task automatic test_back_to_back();
        int         i;
        logic [3:0] seen_v;
        logic [3:0] exp_v;
        waits = 4'h0;
        code  = bcs_pkg::BCS_CODE_IO_RD;
        req   = 1'b1;
        i     = 0;
        #1;
        while (ack !== 1'b1)
        begin
            @(negedge clock);
            #1;
            i++;
            if (i > 40)
                timeout("b2b_first");
        end
        // code only has to be valid where it is taken
        @(negedge clock);
        code = bcs_pkg::BCS_CODE_IO_WR;
        i    = 1;
        #1;
        while (ack !== 1'b1)
        begin
            @(negedge clock);
            #1;
            i++;
            if (i > 40)
                timeout("b2b_second");
        end
        // taken at end of T3: T4, T1, T2, T3 of two clocks each
        check("b2b_gap", 4'(i), 4'h8);
        @(negedge clock);
        req      = 1'b0;
        hold_cmd = 1'b1;
        seen_v   = first_q ? {2'h0, pins.mem_io, pins.dir} : {1'h0, pins.status};
        exp_v    = first_q ? {2'h0, bcs_pkg::BCS_CODE_IO_WR[2:1]} : {1'h0, bcs_pkg::BCS_CODE_IO_WR};
        check("b2b_lead", seen_v, exp_v);
        i = 0;
        while ((first_q ? rel_ack : !st_oe) !== 1'b1)
        begin
            @(negedge clock);
            i++;
            if (i > 20)
                timeout("b2b_release");
        end
        // hold raised in lead-in T4; bus let go mid final T4
        check("hold_t4", 4'(i), 4'h9);
        hold_cmd = 1'b0;
        repeat (8) @(negedge clock);
        $display("back to back test done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        do_reset(1'b1);
        test_reset();
        for (int c = 0; c < 7; c++)
            run_cycle(3'(c), 4'h0);
        test_back_to_back();
        run_cycle(bcs_pkg::BCS_CODE_MEM_RD, 4'h8);
        test_hold();
        do_reset(1'b0);
        // pin flips after reset; selection must stay put
        cfg = 1'b1;
        repeat (4) @(negedge clock);
        test_reset();
        for (int c = 0; c < 7; c++)
            run_cycle(3'(c), 4'h0);
        test_back_to_back();
        run_cycle(bcs_pkg::BCS_CODE_MEM_RD, 4'h8);
        test_hold();
        stop_test();
    end
endmodule
`default_nettype wire
